// ==== pkg/pp_sig_pkg.sv ====
// constants for the parallel port host signalling block
// assumes a single 200 MHz clock and synchronous active-low reset
//
// Summary of operation
// - in EPP mode the select input has no fixed meaning and is only passed on as a status level.
// - in compatibility mode selectin is driven low to select the peripheral and high to request an advanced mode.
// - in ECP mode selectin is held high, and driven low to end ECP and return to compatibility mode.
// - in EPP mode selectin goes low as an address strobe only during address read or write cycles.
// - in compatibility mode strobe pulses low to latch data, with data held valid the whole time it is low.
// - ECP forward bytes move by a closed-loop handshake of strobe from the host answered by busy.
// - in EPP mode strobe is low during write cycles and high during read cycles.
package pp_sig_pkg;
  // port modes
  localparam logic [1:0] MODE_COMPAT = 2'h0;
  localparam logic [1:0] MODE_ECP    = 2'h1;
  localparam logic [1:0] MODE_EPP    = 2'h2;

  // compatibility strobe timing
  localparam int STB_SETUP_NS = 500;
  localparam int STB_WIDTH_NS = 500;
  localparam int CLK_NS       = 5;
  localparam logic [7:0] STB_SETUP_CYC = 8'((STB_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] STB_WIDTH_CYC = 8'((STB_WIDTH_NS + CLK_NS - 1) / CLK_NS);

  // output reset levels
  localparam logic STROBE_RST   = 1'b1;
  localparam logic SELECTIN_RST = 1'b0;
endpackage

// ==== hw/pp_sync2.sv ====
// two-flop synchroniser bank for the peripheral and DMA inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/10ps
module pp_sync2 #(
  parameter int W = 4
) (
  input  wire logic         clk,  // system clock
  input  wire logic         nrst, // sync reset, active low
  input  wire logic [W-1:0] d,    // asynchronous inputs
  output logic      [W-1:0] q     // synchronised outputs
);
  logic [W-1:0] meta_q;

  // first stage only feeds the second stage
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ==== hw/pp_host_sig.sv ====
// host-side control signalling of a 1284 parallel port: strobe, selectin, select status, terminal count
// assumes the user side gives one request at a time and holds data while busy_o is high
`timescale 1ns/10ps
module pp_host_sig
  import pp_sig_pkg::*;
(
  input  wire logic       clk,            // 200 MHz clock
  input  wire logic       nrst,           // sync reset, active low
  input  wire logic [1:0] mode,           // pp_sig_pkg::MODE_*
  input  wire logic       adv_req,        // request advanced mode (compat)
  input  wire logic       ecp_exit,       // end ECP, return to compat
  input  wire logic       xfer_req,       // start one byte cycle
  input  wire logic       xfer_write,     // EPP: 1 write, 0 read
  input  wire logic       xfer_addr,      // EPP: address cycle
  input  wire logic [7:0] xfer_data,      // byte to send
  input  wire logic       select_pin,     // SELECT from peripheral
  input  wire logic       busy_pin,       // BUSY from peripheral
  input  wire logic       dma_tc_pin,     // terminal count
  input  wire logic       parallel_dma_acknowledge_n, // DMA acknowledge, low active
  output logic            strobe_n_o,     // STROBE pin
  output logic            selectin_o,     // SELECTIN pin
  output logic [7:0]      data_o,         // data lines
  output logic            data_oe_o,      // data drive enable
  output logic            busy_o,         // cycle in progress
  output logic            done_o,         // one-cycle end of byte
  output logic            online_o,       // printer online
  output logic            ext_ack_o,      // ECP extensibility answer
  output logic            user_sel_o,     // EPP user status
  output logic            dma_done_o      // one-cycle DMA complete
);
  import pp_sig_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_ECP_WAIT, ST_ECP_REL, ST_EPP} state_e;

  logic [3:0]  sy;
  logic        sel_s, busy_s, tc_s;
  state_e      st_q, st_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        strobe_q, selin_q, oe_q, busy_q, done_q;
  logic        online_q, ext_q, usr_q, tc_q, tc_prev_q, ecp_end_q;
  logic [7:0]  data_q;
  logic        epp_wr_q, epp_ad_q;

  // each pin is synchronised on its own; gating two async pins ahead of the flops could glitch into stage one
  pp_sync2 #(.W(4)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({select_pin, busy_pin, dma_tc_pin, parallel_dma_acknowledge_n}),
    .q    (sy)
  );
  assign sel_s  = sy[3];
  assign busy_s = sy[2];
  assign tc_s   = sy[1] & ~sy[0];

  // mode decode
  wire is_compat = (mode == MODE_COMPAT);
  wire is_ecp    = (mode == MODE_ECP);
  wire is_epp    = (mode == MODE_EPP);
  wire start     = xfer_req && (st_q == ST_IDLE);
  wire cnt_zero  = (cnt_q == 8'h00);

  // next state; ECP waits for busy to rise then fall before idling
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_zero ? 8'h00 : cnt_q - 8'h01;
    case (st_q)
      ST_IDLE:
      begin
        if (start && is_compat)
        begin
          st_d  = ST_SETUP;
          cnt_d = STB_SETUP_CYC;
        end
        else if (start && is_ecp)
          st_d = ST_ECP_WAIT;
        else if (start && is_epp)
          st_d = ST_EPP;
      end
      ST_SETUP:
      begin
        if (cnt_zero)
        begin
          st_d  = ST_PULSE;
          cnt_d = STB_WIDTH_CYC;
        end
      end
      ST_PULSE:    if (cnt_zero) st_d = ST_IDLE;
      ST_ECP_WAIT: if (busy_s) st_d = ST_ECP_REL;
      ST_ECP_REL:  if (!busy_s) st_d = ST_IDLE;
      ST_EPP:      st_d = ST_IDLE;
      default:     st_d = ST_IDLE;
    endcase
  end

  // strobe level for the next cycle
  wire stb_d = (st_d == ST_PULSE) ? 1'b0 :
               (st_d == ST_ECP_WAIT) ? 1'b0 :
               (st_d == ST_EPP) ? ~(start ? xfer_write : epp_wr_q) :
               1'b1;
  // selectin level: compat select/advanced request, ECP high, EPP address strobe
  wire selin_d = is_compat ? adv_req :
                 is_ecp ? ~(ecp_exit | ecp_end_q) :
                 ~((st_d == ST_EPP) && (start ? xfer_addr : epp_ad_q));
  wire fin = (st_q != ST_IDLE) && (st_d == ST_IDLE);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 8'h00;
      strobe_q <= STROBE_RST;
      selin_q <= SELECTIN_RST;
      data_q <= 8'h00;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      epp_wr_q <= 1'b0;
      epp_ad_q <= 1'b0;
      ecp_end_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      strobe_q <= stb_d;
      selin_q <= selin_d;
      busy_q <= (st_d != ST_IDLE);
      done_q <= fin;
      ecp_end_q <= is_ecp & (ecp_exit | ecp_end_q);
      if (start)
      begin
        data_q <= xfer_data; // held for the whole strobe low time
        oe_q <= ~is_epp | xfer_write;
        epp_wr_q <= xfer_write;
        epp_ad_q <= xfer_addr;
      end
    end
  end

  // status levels from select, and a one-cycle pulse from terminal count
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      online_q <= 1'b0;
      ext_q <= 1'b0;
      usr_q <= 1'b0;
      tc_q <= 1'b0;
      tc_prev_q <= 1'b0;
    end
    else
    begin
      online_q <= is_compat & sel_s;
      ext_q <= is_compat & adv_req & sel_s;
      usr_q <= is_epp & sel_s;
      tc_prev_q <= tc_s;
      tc_q <= tc_s & ~tc_prev_q;
    end
  end

  assign strobe_n_o = strobe_q;
  assign selectin_o = selin_q;
  assign data_o     = data_q;
  assign data_oe_o  = oe_q;
  assign busy_o     = busy_q;
  assign done_o     = done_q;
  assign online_o   = online_q;
  assign ext_ack_o  = ext_q;
  assign user_sel_o = usr_q;
  assign dma_done_o = tc_q;

  a_stb_width: assert property (@(posedge clk) disable iff (!nrst)
    $fell(strobe_q) && is_compat |-> !strobe_q [*8])
    else $error("compat strobe too short");
  a_data_hold: assert property (@(posedge clk) disable iff (!nrst)
    !strobe_q && is_compat |-> $stable(data_q))
    else $error("data changed while strobe low");
  a_ecp_hand: assert property (@(posedge clk) disable iff (!nrst)
    st_q == ST_ECP_WAIT && !busy_s |=> !strobe_q)
    else $error("ecp strobe released before busy");
  a_ecp_next: assert property (@(posedge clk) disable iff (!nrst)
    st_q == ST_ECP_REL && busy_s |=> st_q != ST_IDLE)
    else $error("ecp idle before busy fell");
  a_ecp_selin: assert property (@(posedge clk) disable iff (!nrst)
    is_ecp && !ecp_exit && !ecp_end_q && $past(is_ecp) |=> selin_q)
    else $error("selectin low in ecp");
  a_epp_addr: assert property (@(posedge clk) disable iff (!nrst)
    is_epp && $past(is_epp) && st_q == ST_IDLE && $past(st_q) == ST_IDLE |-> selin_q)
    else $error("epp address strobe outside cycle");
  a_epp_dir: assert property (@(posedge clk) disable iff (!nrst)
    st_q == ST_EPP |-> strobe_q == ~epp_wr_q)
    else $error("epp strobe direction wrong");
  a_compat_sel: assert property (@(posedge clk) disable iff (!nrst)
    is_compat && $past(is_compat) |-> selin_q == $past(adv_req))
    else $error("compat selectin wrong");
  a_user_sel: assert property (@(posedge clk) disable iff (!nrst)
    !is_epp |=> !usr_q)
    else $error("user select outside epp");
  a_tc_pulse: assert property (@(posedge clk) disable iff (!nrst)
    tc_q |=> !tc_q)
    else $error("dma done not a pulse");

  c_compat: cover property (@(posedge clk) st_q == ST_PULSE ##1 st_q == ST_IDLE);
  c_ecp: cover property (@(posedge clk) st_q == ST_ECP_REL ##1 st_q == ST_IDLE);
  c_epp: cover property (@(posedge clk) st_q == ST_EPP && !selin_q);
  c_tc: cover property (@(posedge clk) tc_q);
endmodule

// ==== dv/pp_periph.sv ====
// peripheral model: select level and a slow ECP busy answer
// assumes one clock shared with the host block
`timescale 1ns/10ps
module pp_periph (
  input  wire logic clk,        // clock
  input  wire logic strobe_n,   // host strobe
  input  wire logic sel_lvl,    // select level to show
  output logic      select_pin, // select to host
  output logic      busy_pin    // busy to host
);
  logic [1:0] dly_q = 2'h0;
  // busy trails strobe three clocks so the host cannot skip the wait
  always_ff @(posedge clk)
  begin
    dly_q <= {dly_q[0], ~strobe_n};
    busy_pin <= dly_q[1];
  end
  assign select_pin = sel_lvl;
endmodule

// ==== dv/ieee1284_host_signaling_bench.sv ====
// bench for the host strobe and selectin logic
// assumes the peripheral model stands on the pin side
`timescale 1ns/10ps
module ieee1284_host_signaling_bench;
  import pp_sig_pkg::*;
  logic clk, nrst, adv_req, ecp_exit, xfer_req, xfer_write, xfer_addr, sel_lvl;
  logic [1:0] mode;
  logic [7:0] xfer_data, data_o;
  logic select_pin, busy_pin, dma_tc_pin, parallel_dma_acknowledge_n, prev_stb;
  logic strobe_n_o, selectin_o, data_oe_o, busy_o, done_o, online_o, ext_ack_o, user_sel_o, dma_done_o;
  logic [31:0] seed = 32'h3B74;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  pp_host_sig DUT (.clk(clk), .nrst(nrst), .mode(mode), .adv_req(adv_req), .ecp_exit(ecp_exit),
    .xfer_req(xfer_req), .xfer_write(xfer_write), .xfer_addr(xfer_addr), .xfer_data(xfer_data),
    .select_pin(select_pin), .busy_pin(busy_pin), .dma_tc_pin(dma_tc_pin),
    .parallel_dma_acknowledge_n(parallel_dma_acknowledge_n), .strobe_n_o(strobe_n_o),
    .selectin_o(selectin_o), .data_o(data_o), .data_oe_o(data_oe_o), .busy_o(busy_o), .done_o(done_o),
    .online_o(online_o), .ext_ack_o(ext_ack_o), .user_sel_o(user_sel_o), .dma_done_o(dma_done_o));
  pp_periph PER (.clk(clk), .strobe_n(strobe_n_o), .sel_lvl(sel_lvl), .select_pin(select_pin),
    .busy_pin(busy_pin));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one byte cycle; the note goes on the queue only when a byte leaves
  task automatic byte_cyc(input logic w, input logic a);
    int n;
    seed = xs(seed);
    if (w)
      exp_q.push_back(seed[7:0]);
    @(posedge clk);
    xfer_req <= 1'b1;
    xfer_write <= w;
    xfer_addr <= a;
    xfer_data <= seed[7:0];
    @(posedge clk);
    xfer_req <= 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    chk(n < 2000, "no done");
    chk(busy_o === 1'b0, "busy after done");
  endtask
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask
  // watcher: data must sit on the lines from the strobe's fall
  always @(negedge clk)
  begin
    if (nrst && strobe_n_o === 1'b0 && prev_stb === 1'b1)
    begin
      chk(exp_q.size() > 0 && data_o === exp_q[0] && data_oe_o === 1'b1, "data at strobe");
      if (exp_q.size() > 0)
        void'(exp_q.pop_front());
    end
    if (nrst && mode == MODE_ECP && prev_stb === 1'b0 && strobe_n_o === 1'b1)
      chk(busy_pin === 1'b1, "strobe rose before busy");
    if (nrst && busy_o === 1'b1 && mode == MODE_EPP)
      chk(strobe_n_o === ~xfer_write && selectin_o === ~xfer_addr, "epp strobes");
    prev_stb = strobe_n_o;
  end
  initial
  begin
    #50000;
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    finish_test;
  end
  initial
  begin
    {nrst, adv_req, ecp_exit, xfer_req, xfer_addr, xfer_data, dma_tc_pin} = '0;
    {xfer_write, sel_lvl, parallel_dma_acknowledge_n} = 3'h7;
    mode = MODE_COMPAT;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    settle;
    chk(online_o === 1'b1 && selectin_o === 1'b0, "compat idle");
    // inputs only move on the rising edge, checks sit on the falling one
    @(posedge clk);
    adv_req <= 1'b1;
    settle;
    chk(selectin_o === 1'b1 && ext_ack_o === 1'b1, "advanced request");
    @(posedge clk);
    sel_lvl <= 1'b0;
    settle;
    chk(ext_ack_o === 1'b0 && online_o === 1'b0, "mode refused");
    @(posedge clk);
    {adv_req, sel_lvl} <= 2'h1;
    byte_cyc(1'b1, 1'b0);
    byte_cyc(1'b1, 1'b0);
    $display("compat test done");
    @(posedge clk);
    mode <= MODE_ECP;
    settle;
    chk(selectin_o === 1'b1 && online_o === 1'b0, "ecp idle");
    byte_cyc(1'b1, 1'b0);
    chk(busy_pin === 1'b0, "ecp not idle at done");
    byte_cyc(1'b1, 1'b1);
    @(posedge clk);
    ecp_exit <= 1'b1;
    settle;
    chk(selectin_o === 1'b0, "ecp exit");
    @(posedge clk);
    ecp_exit <= 1'b0;
    $display("ecp test done");
    mode <= MODE_EPP;
    settle;
    chk(user_sel_o === 1'b1 && selectin_o === 1'b1 && online_o === 1'b0, "epp idle");
    for (int i = 0; i < 4; i++)
      byte_cyc(i[0], i[1]);
    $display("epp test done");
    // terminal count while the acknowledge is still high must not end the transfer
    @(posedge clk);
    {dma_tc_pin, parallel_dma_acknowledge_n} <= 2'h3;
    for (int i = 0; i < 5; i++)
    begin
      @(negedge clk);
      chk(dma_done_o === 1'b0, "tc without acknowledge");
    end
    @(posedge clk);
    {dma_tc_pin, parallel_dma_acknowledge_n} <= 2'h2;
    for (int i = 0; i < 8 && dma_done_o !== 1'b1; i++)
      @(negedge clk);
    chk(dma_done_o === 1'b1, "terminal count");
    $display("dma test done");
    finish_test;
  end
endmodule
